// ---- hdl/rtsp_pkg.sv ----
`default_nettype none

package rtsp_pkg;

  // ********************************************************
  // Timing
  // ********************************************************
  localparam int unsigned RTSP_CLK_PERIOD_NS = 100;
  localparam int unsigned RTSP_SAMPLE_DELAY_NS = 1500;
  // Least time, so round up; never below one cycle
  localparam int unsigned RTSP_SAMPLE_DELAY_RAW =
    (RTSP_SAMPLE_DELAY_NS + RTSP_CLK_PERIOD_NS - 1) / RTSP_CLK_PERIOD_NS;
  localparam int unsigned RTSP_SAMPLE_DELAY_CYC =
    (RTSP_SAMPLE_DELAY_RAW < 1) ? 1 : RTSP_SAMPLE_DELAY_RAW;
  localparam int unsigned RTSP_TMR_W = 8;

  // ********************************************************
  // Test pins
  // ********************************************************
  localparam int unsigned RTSP_NUM_TEST_PINS = 8;
  localparam logic [7:0] RTSP_SEL_RST = 8'h00;
  localparam logic [7:0] RTSP_SEL_NORMAL = 8'h00;
  localparam logic [7:0] RTSP_PAD_OE_OFF = 8'h00;
  localparam logic [7:0] RTSP_PAD_OE_ON = 8'hff;
  localparam logic [7:0] RTSP_PAD_PD_ON = 8'hff;
  localparam logic [7:0] RTSP_PAD_PD_OFF = 8'h00;
  localparam logic [7:0] RTSP_PAD_OUT_RST = 8'h00;

  // ********************************************************
  // Types
  // ********************************************************
  typedef enum logic [1:0] {
    rtsp_st_hold,
    rtsp_st_wait,
    rtsp_st_run
  } rtsp_phase_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pd;
  } rtsp_pad_t;

  typedef struct packed {
    logic config_start;
    logic config_busy;
    logic sample_done;
    logic outputs_active;
    logic normal_mode;
    logic test_mode;
    logic test_port_fault;
    logic [7:0] test_sel;
  } rtsp_status_t;

  typedef struct packed {
    rtsp_phase_t phase;
    logic por_prev;
    rtsp_pad_t pad;
    rtsp_status_t status;
  } rtsp_state_t;

endpackage : rtsp_pkg

`default_nettype wire

// ---- hdl/rtsp_cycle_timer.sv ----
`timescale 1ns/1ps
`default_nettype none

module rtsp_cycle_timer
  import rtsp_pkg::*;
#(
  parameter int unsigned W = RTSP_TMR_W,
  parameter int unsigned COUNT = RTSP_SAMPLE_DELAY_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Control
  input wire logic start,
  input wire logic abort,
  // Result
  output logic busy,
  output logic done
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic busy;
    logic done;
  } rtsp_tmr_state_t;

  localparam logic [W-1:0] LOAD = W'(COUNT - 1);

  rtsp_tmr_state_t s_r;
  rtsp_tmr_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (abort) begin
      s_nxt.busy = 1'b0;
      s_nxt.cnt = '0;
    end else if (start) begin
      s_nxt.busy = 1'b1;
      s_nxt.cnt = LOAD;
    end else if (s_r.busy) begin
      if (s_r.cnt == '0) begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt - W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign busy = s_r.busy;
  assign done = s_r.done;

endmodule : rtsp_cycle_timer

`default_nettype wire

// ---- hdl/rtsp_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module rtsp_top
  import rtsp_pkg::*;
(
  // Clock and chip reset
  input wire logic clk,
  input wire logic resetn,
  // Power-on reset from the supervisor
  input wire logic power_on_reset_n,
  // Internal test port reset strap
  input wire logic test_port_reset_n,
  // Test point pads
  input wire logic [7:0] test_point_in,
  output logic [7:0] test_point_out,
  output logic [7:0] test_point_oe,
  output logic [7:0] test_point_pd_en,
  // Test data from the core, shown on the pads in test mode
  input wire logic [7:0] test_data,
  // Status towards the core
  output logic config_start,
  output logic config_busy,
  output logic sample_done,
  output logic outputs_active,
  output logic normal_mode,
  output logic test_mode,
  output logic [7:0] test_sel,
  output logic test_port_fault
);

  // ********************************************************
  // State
  // ********************************************************
  rtsp_state_t s_r;
  rtsp_state_t s_nxt;

  logic tmr_busy;
  logic tmr_done;
  logic por_rise;
  logic por_low;

  // ********************************************************
  // Sampling delay timer
  // ********************************************************
  // Started by the registered start pulse, so the pads are
  // sampled a couple of cycles later than the bare delay;
  // the pin timing is only approximate, this is harmless.
  rtsp_cycle_timer #(
    .W(RTSP_TMR_W),
    .COUNT(RTSP_SAMPLE_DELAY_CYC)
  ) u_sample_timer (
    .clk(clk),
    .resetn(resetn),
    .start(s_r.status.config_start),
    .abort(por_low),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  // ********************************************************
  // Reset edge detection
  // ********************************************************
  // The supervisor releases only once supplies and clocks
  // are stable, so no qualification beyond the edge.
  assign por_rise = power_on_reset_n & ~s_r.por_prev;
  assign por_low = ~power_on_reset_n;

  // ********************************************************
  // Next state
  // ********************************************************
  always_comb begin
    s_nxt = s_r;
    s_nxt.por_prev = power_on_reset_n;
    s_nxt.status.config_start = 1'b0;
    s_nxt.status.sample_done = 1'b0;

    case (s_r.phase)
      rtsp_st_hold: begin
        s_nxt.status.config_busy = 1'b0;
        if (por_rise) begin
          s_nxt.phase = rtsp_st_wait;
          s_nxt.status.config_start = 1'b1;
          s_nxt.status.config_busy = 1'b1;
        end
      end

      rtsp_st_wait: begin
        // Pads still released and pulled down while waiting
        if (tmr_done) begin
          s_nxt.phase = rtsp_st_run;
          s_nxt.status.test_sel = test_point_in;
          s_nxt.status.sample_done = 1'b1;
          s_nxt.status.config_busy = 1'b0;
          // An open pin reads low through its pulldown.
          // A pulled-high pin selects a test mode.
          s_nxt.status.normal_mode = (test_point_in == RTSP_SEL_NORMAL);
          s_nxt.status.test_mode = (test_point_in != RTSP_SEL_NORMAL);
          s_nxt.status.outputs_active = 1'b1;
        end
      end

      rtsp_st_run: begin
        // Selection stays latched until reset is asserted again.
        s_nxt.status.outputs_active = 1'b1;
      end

      default: begin
        s_nxt.phase = rtsp_st_hold;
      end
    endcase

    // ********************************************************
    // Pad control
    // ********************************************************
    // Drive only once the pattern is latched, otherwise the
    // sample would see our own levels instead of the straps.
    if (s_nxt.phase == rtsp_st_run) begin
      s_nxt.pad.oe = RTSP_PAD_OE_ON;
      s_nxt.pad.pd = RTSP_PAD_PD_OFF;
      s_nxt.pad.out = s_nxt.status.test_mode ? test_data : RTSP_PAD_OUT_RST;
    end else begin
      s_nxt.pad.oe = RTSP_PAD_OE_OFF;
      s_nxt.pad.pd = RTSP_PAD_PD_ON;
      s_nxt.pad.out = RTSP_PAD_OUT_RST;
    end

    // ********************************************************
    // Test port reset supervision
    // ********************************************************
    // Only flagged: a high strap is a board fault the core
    // should report, the device cannot correct it.
    s_nxt.status.test_port_fault = (s_nxt.phase != rtsp_st_hold) & test_port_reset_n;

    // ********************************************************
    // Power-on reset asserted: everything back to rest
    // ********************************************************
    if (por_low) begin
      s_nxt.phase = rtsp_st_hold;
      s_nxt.pad.oe = RTSP_PAD_OE_OFF;
      s_nxt.pad.pd = RTSP_PAD_PD_ON;
      s_nxt.pad.out = RTSP_PAD_OUT_RST;
      s_nxt.status.config_start = 1'b0;
      s_nxt.status.config_busy = 1'b0;
      s_nxt.status.sample_done = 1'b0;
      s_nxt.status.outputs_active = 1'b0;
      s_nxt.status.normal_mode = 1'b0;
      s_nxt.status.test_mode = 1'b0;
      s_nxt.status.test_port_fault = 1'b0;
      s_nxt.status.test_sel = RTSP_SEL_RST;
    end
  end

  // ********************************************************
  // State register
  // ********************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_r.phase <= rtsp_st_hold;
      s_r.por_prev <= 1'b0;
      s_r.pad.out <= RTSP_PAD_OUT_RST;
      s_r.pad.oe <= RTSP_PAD_OE_OFF;
      s_r.pad.pd <= RTSP_PAD_PD_ON;
      s_r.status <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ********************************************************
  // Outputs
  // ********************************************************
  assign test_point_out = s_r.pad.out;
  assign test_point_oe = s_r.pad.oe;
  assign test_point_pd_en = s_r.pad.pd;
  assign config_start = s_r.status.config_start;
  assign config_busy = s_r.status.config_busy;
  assign sample_done = s_r.status.sample_done;
  assign outputs_active = s_r.status.outputs_active;
  assign normal_mode = s_r.status.normal_mode;
  assign test_mode = s_r.status.test_mode;
  assign test_sel = s_r.status.test_sel;
  assign test_port_fault = s_r.status.test_port_fault;

endmodule : rtsp_top

`default_nettype wire

// ---- testbench/rtsp_top_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none

module rtsp_top_monitor
  import rtsp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Straps and pads
  input wire logic power_on_reset_n,
  input wire logic test_port_reset_n,
  input wire logic [7:0] test_point_in,
  input wire logic [7:0] test_point_out,
  input wire logic [7:0] test_point_oe,
  input wire logic [7:0] test_point_pd_en,
  input wire logic [7:0] test_data,
  // Status
  input wire logic config_start,
  input wire logic config_busy,
  input wire logic sample_done,
  input wire logic outputs_active,
  input wire logic normal_mode,
  input wire logic test_mode,
  input wire logic [7:0] test_sel,
  input wire logic test_port_fault
);
  // ********************************************************
  // Checks
  // ********************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_release;
    $rose(power_on_reset_n);
  endsequence
  sequence s_running;
    outputs_active && $past(outputs_active);
  endsequence

  chk_start_on_rise: assert property (s_release |=> config_start) else $error("no start after release");
  chk_hold_quiet: assert property (!power_on_reset_n |=> !outputs_active && !config_busy && test_point_oe == 8'h00)
    else $error("outputs live in hold");
  chk_pulldown_pair: assert property (test_point_pd_en == ~test_point_oe) else $error("pulldown not opposite oe");
  // A low reset pin aborts the wait, so the delay is only judged on runs left alone
  chk_sample_delay: assert property (@(posedge clk) disable iff (!resetn || !power_on_reset_n)
    config_start |-> ##17 sample_done) else $error("sample delay wrong");
  chk_busy_until: assert property (sample_done |-> !config_busy && $past(config_busy)) else $error("busy wrong");
  chk_drive_after: assert property (sample_done |-> test_point_oe == 8'hff && outputs_active)
    else $error("pads not driven");
  chk_sel_latch: assert property (sample_done |-> test_sel == $past(test_point_in) &&
    normal_mode == ($past(test_point_in) == 8'h00) && test_mode == !normal_mode) else $error("bad latch");
  chk_sel_stable: assert property (s_running |-> $stable(test_sel)) else $error("selection moved");
  chk_pad_data: assert property (s_running |-> test_point_out == (test_mode ? $past(test_data) : 8'h00))
    else $error("pad data wrong");
  // In the run phase a high strap must show as a fault one cycle later
  chk_fault_flag: assert property (s_running |-> test_port_fault == $past(test_port_reset_n))
    else $error("strap fault flag wrong");
endmodule : rtsp_top_monitor

`default_nettype wire

// ---- testbench/rtsp_supervisor.sv ----
`timescale 1ns/1ps
`default_nettype none

module rtsp_supervisor (
  // Clock
  input wire logic clk,
  // Straps
  output logic power_on_reset_n,
  output logic test_port_reset_n,
  // Pad wires
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] pad_pd_en,
  input wire logic [7:0] ext_val,
  input wire logic [7:0] ext_en,
  output logic [7:0] pad_in
);
  // ********************************************************
  // Supervisor and pad wire
  // ********************************************************
  initial begin
    power_on_reset_n = 1'b0;
    test_port_reset_n = 1'b0;
  end
  // Device drive wins; an external driver beats the weak pull only when enabled
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pad_in[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i] : !pad_pd_en[i];
    end
  end
  task automatic set_por(input logic v);
    @(posedge clk) power_on_reset_n <= v;
  endtask : set_por
  task automatic set_strap(input logic v);
    @(posedge clk) test_port_reset_n <= v;
  endtask : set_strap
endmodule : rtsp_supervisor

`default_nettype wire

// ---- testbench/test_rtsp_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module test_rtsp_top;
  import rtsp_pkg::*;
  logic clk;
  logic resetn;
  logic [7:0] test_data;
  logic [7:0] ext_val;
  logic [7:0] ext_en;
  logic power_on_reset_n, test_port_reset_n, config_start, config_busy, sample_done;
  logic outputs_active, normal_mode, test_mode, test_port_fault;
  logic [7:0] test_point_in, test_point_out, test_point_oe, test_point_pd_en, test_sel;
  int fail_count = 0;
  int checked = 0;
  int n;

  rtsp_top dut (.*);
  rtsp_supervisor sup (.clk(clk), .power_on_reset_n(power_on_reset_n), .test_port_reset_n(test_port_reset_n),
    .pad_out(test_point_out), .pad_oe(test_point_oe), .pad_pd_en(test_point_pd_en), .ext_val(ext_val),
    .ext_en(ext_en), .pad_in(test_point_in));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ********************************************************
  // Helpers
  // ********************************************************
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic stop_test;
    $display("mismatches=%0d checks=%0d", fail_count, checked);
    if (fail_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  // Counts cycles from the start pulse to the sample pulse
  task automatic wait_sample(output int c);
    c = 0;
    while (config_start !== 1'b1 && c < 40) begin @(negedge clk); c++; end
    c = 0;
    while (sample_done !== 1'b1 && c < 40) begin @(negedge clk); c++; end
  endtask : wait_sample

  // ********************************************************
  // Scenarios
  // ********************************************************
  task automatic test_hold;
    repeat (3) @(negedge clk);
    cmp(test_point_oe, 8'h00);
    cmp(test_point_pd_en, 8'hff);
    cmp({4'h0, outputs_active, config_busy, normal_mode, test_mode}, 8'h00);
  endtask : test_hold
  task automatic test_normal;
    sup.set_por(1'b1);
    wait_sample(n);
    cmp(8'(n), 8'(RTSP_SAMPLE_DELAY_CYC + 2));
    cmp(test_sel, 8'h00);
    cmp({5'h00, normal_mode, test_mode, outputs_active}, 8'h05);
    cmp(test_point_oe, 8'hff);
    cmp(test_point_out, 8'h00);
  endtask : test_normal
  task automatic test_pattern;
    @(posedge clk);
    ext_val <= 8'ha5;
    ext_en <= 8'hf0;
    sup.set_por(1'b0);
    repeat (2) @(negedge clk);
    cmp(test_point_oe, 8'h00);
    cmp(test_sel, 8'h00);
    sup.set_por(1'b1);
    wait_sample(n);
    cmp(test_sel, 8'ha0);
    cmp({6'h00, normal_mode, test_mode}, 8'h01);
    @(posedge clk);
    ext_en <= 8'h00;
    test_data <= 8'h3c;
    repeat (3) @(negedge clk);
    cmp(test_point_out, 8'h3c);
    cmp(test_sel, 8'ha0);
  endtask : test_pattern
  task automatic test_abort;
    sup.set_por(1'b0);
    sup.set_por(1'b1);
    repeat (5) @(negedge clk);
    sup.set_por(1'b0);
    sup.set_por(1'b1);
    repeat (2) @(negedge clk);
    wait_sample(n);
    cmp(8'(n), 8'(RTSP_SAMPLE_DELAY_CYC + 2));
    cmp(test_sel, 8'h00);
  endtask : test_abort
  task automatic test_strap;
    sup.set_strap(1'b1);
    repeat (2) @(negedge clk);
    cmp({7'h00, test_port_fault}, 8'h01);
    sup.set_strap(1'b0);
    repeat (2) @(negedge clk);
    cmp({7'h00, test_port_fault}, 8'h00);
  endtask : test_strap

  initial begin
    // Driven from here rather than fixed at declaration, so every input stays under stimulus control
    resetn <= 1'b0;
    test_data <= 8'h00;
    ext_val <= 8'h00;
    ext_en <= 8'h00;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    test_hold();
    test_normal();
    test_pattern();
    test_abort();
    test_strap();
    stop_test();
  end
  // Whole run takes about 100 cycles
  initial begin
    repeat (2000) @(posedge clk);
    fail_count++;
    stop_test();
  end
endmodule : test_rtsp_top

bind rtsp_top rtsp_top_monitor mon (.*);

`default_nettype wire
